// >>> fssl_pkg.sv
// Purpose: shared constants and carriers for the parallel flash status/lockdown controller
// Assumes: hclk at 250 MHz; flash word bus 16 bits, address 20 bits
// Notes:   pin timings not fixed elsewhere are plain defaults, tune per board
package fssl_pkg;

    // clock and pin timing, times in ns, counts in hclk cycles
    localparam int CLK_NS       = 4;                           // hclk period
    localparam int T_ACC_NS     = 80;                          // read access time
    localparam int T_SETUP_NS   = 20;                          // address/ce setup before strobe
    localparam int T_WP_NS      = 40;                          // write strobe low width
    localparam int T_HOLD_NS    = 20;                          // hold after strobe release
    localparam int SYNC_STAGES  = 2;                           // dq sampled through two flops
    localparam logic [7:0] ACC_CYC   = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
    localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] WP_CYC    = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] HOLD_CYC  = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] POLL_LIMIT = 16'h0fff;             // read pairs before timeout

    // widths
    localparam int ADDR_W = 20;                                // flash word address
    localparam int DATA_W = 16;                                // flash word

    // register byte offsets (low byte of haddr)
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_WDATA  = 8'h08;
    localparam logic [7:0] OFS_RDATA  = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // control register fields
    localparam int CTRL_OP_LSB  = 0;                           // two-bit operation code
    localparam int CTRL_RST_BIT = 4;                           // 1 holds flash reset low
    localparam int CTRL_VPP_BIT = 5;                           // 1 switches program supply on

    // status register fields
    localparam int ST_BUSY = 0;                                // operation running
    localparam int ST_DONE = 1;                                // sticky, write 1 to clear
    localparam int ST_PULS = 2;                                // sticky, pulse limit / locked
    localparam int ST_VPPL = 3;                                // sticky, supply too low
    localparam int ST_TMO  = 4;                                // sticky, poll budget spent
    localparam int ST_RDY  = 5;                                // synchronised ready pin

    // status bits on the flash data bus
    localparam int DQ_TOGGLE = 6;
    localparam int DQ_PULSE  = 5;
    localparam int DQ_VPPLOW = 3;

    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST  = 20'h00000;
    localparam logic [DATA_W-1:0] WDATA_RST = 16'h0000;

    // operation codes written to the control register
    typedef enum logic [1:0] {
        FSSL_OP_NONE  = 2'b00,
        FSSL_OP_WRITE = 2'b01,
        FSSL_OP_READ  = 2'b10,
        FSSL_OP_POLL  = 2'b11
    } fssl_op_t;

    // one flash bus cycle request
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fssl_req_t;

    // flash pins driven by the controller
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic              dq_oe;
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
    } fssl_pin_o_t;

endpackage

// >>> fssl_cycle.sv
// Purpose: runs one asynchronous flash bus cycle, write or read, on the pins
// Assumes: one request at a time; next request only after done
// Notes:   all pins come from flops; read data passes two sync flops
`timescale 1ns/10ps
module fssl_cycle (
    input  wire logic                   hclk,      // system clock
    input  wire logic                   hresetn,   // async reset, active low
    input  wire logic                   req_valid, // one-cycle start pulse
    input  wire fssl_pkg::fssl_req_t    req,       // cycle to run
    input  wire logic [15:0]            dq_i,      // data pins as seen
    output logic                        done,      // one-cycle end pulse
    output logic [15:0]                 rdata,     // sampled read word
    output fssl_pkg::fssl_pin_o_t       pins       // flash pin drive
);
    import fssl_pkg::*;

    typedef enum logic [3:0] {
        C_IDLE   = 4'b0001,
        C_SETUP  = 4'b0010,
        C_STROBE = 4'b0100,
        C_HOLD   = 4'b1000
    } fssl_cst_t;

    fssl_cst_t             st_q, st_d;       // cycle phase
    logic [7:0]            cnt_q, cnt_d;     // phase countdown
    logic                  wr_q, wr_d;       // current cycle is a write
    fssl_pin_o_t           pins_q, pins_d;   // pin registers
    logic                  done_q, done_d;   // end pulse
    logic [DATA_W-1:0]     rd_q, rd_d;       // captured word
    logic [DATA_W-1:0]     dq_s1_q;          // first sync stage
    logic [DATA_W-1:0]     dq_s2_q;          // second sync stage

    // pins are asynchronous to hclk; access time already covers both stages
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
        end else begin
            dq_s1_q <= dq_i;
            dq_s2_q <= dq_s1_q;
        end
    end

    // phase sequencing: address and ce first, then strobe, then hold
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        wr_d   = wr_q;
        pins_d = pins_q;
        done_d = 1'b0;
        rd_d   = rd_q;
        unique case (st_q)
            C_IDLE: begin
                if (req_valid) begin
                    wr_d         = req.wr;
                    pins_d.addr  = req.addr;     // stable before any strobe falls
                    pins_d.dq    = req.data;
                    pins_d.dq_oe = req.wr;       // drive data only for writes
                    pins_d.ce_n  = 1'b0;
                    cnt_d        = SETUP_CYC - 8'h01;
                    st_d         = C_SETUP;
                end
            end
            C_SETUP: begin
                if (cnt_q == 8'h00) begin
                    if (wr_q) begin
                        pins_d.we_n = 1'b0;      // we falls last, address taken here
                        cnt_d       = WP_CYC - 8'h01;
                    end else begin
                        pins_d.oe_n = 1'b0;
                        cnt_d       = ACC_CYC - 8'h01;
                    end
                    st_d = C_STROBE;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            C_STROBE: begin
                if (cnt_q == 8'h00) begin
                    if (wr_q) begin
                        pins_d.we_n = 1'b1;      // we rises first, data still held
                    end else begin
                        pins_d.oe_n = 1'b1;
                        rd_d        = dq_s2_q;
                    end
                    cnt_d = HOLD_CYC - 8'h01;
                    st_d  = C_HOLD;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            C_HOLD: begin
                if (cnt_q == 8'h00) begin
                    pins_d.ce_n  = 1'b1;
                    pins_d.dq_oe = 1'b0;         // release bus only after the hold
                    done_d       = 1'b1;
                    st_d         = C_IDLE;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            default: begin
                st_d = C_IDLE;                   // recover from an illegal code
            end
        endcase
    end

    // phase registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q   <= C_IDLE;
            cnt_q  <= 8'h00;
            wr_q   <= 1'b0;
            pins_q <= '{addr: 20'h00000, dq: 16'h0000, dq_oe: 1'b0,
                        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            done_q <= 1'b0;
            rd_q   <= 16'h0000;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            wr_q   <= wr_d;
            pins_q <= pins_d;
            done_q <= done_d;
            rd_q   <= rd_d;
        end
    end

    assign pins  = pins_q;
    assign done  = done_q;
    assign rdata = rd_q;

endmodule

// >>> fssl_ctrl.sv
// Purpose: AHB-Lite controlled host for a parallel NOR flash: bus cycles, status poll
// Assumes: software builds command sequences from single write cycles
// Notes:   one operation at a time; operation codes written while busy are dropped, reset and supply bits still taken
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps

// Operation
// - config 01 needs identification-exit after success
// - any failure needs identification-exit to read
// - config set is four host write cycles
// - bit 5 high holds status until exit
// - bit 3 high means supply too low
// - reset unlocks; six cycles lock a sector
// - single resume cycle continues suspended erase
// - program suspend/resume single cycle, shared codes
// - address on later fall, data earlier rise
module fssl_ctrl (
    input  wire logic                   hclk,         // system clock
    input  wire logic                   hresetn,      // async reset, active low
    input  wire logic                   hsel,         // slave select
    input  wire logic [31:0]            haddr,        // byte address
    input  wire logic [1:0]             htrans,       // transfer type
    input  wire logic                   hwrite,       // write when high
    input  wire logic [2:0]             hsize,        // word transfers only
    input  wire logic [31:0]            hwdata,       // write data
    input  wire logic                   hready,       // bus ready in
    output logic                        hreadyout,    // slave ready out
    output logic [31:0]                 hrdata,       // read data
    output logic                        hresp,        // always okay
    output fssl_pkg::fssl_pin_o_t       flash_o,      // flash address, data, strobes
    input  wire logic [15:0]            flash_dq_i,   // flash data pins in
    input  wire logic                   flash_rdy_i,  // open-drain ready line level
    output logic                        flash_rst_n,  // flash reset, active low
    output logic                        flash_vpp_en  // program supply switch
);
    import fssl_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE   = 4'b0001,
        S_CYC    = 4'b0010,
        S_POLL_A = 4'b0100,
        S_POLL_B = 4'b1000
    } fssl_st_t;

    // bus slave state
    logic                  pend_q, pend_d;       // data phase pending
    logic                  pwr_q, pwr_d;         // pending is a write
    logic [7:0]            pofs_q, pofs_d;       // pending register offset
    logic                  rdyo_q, rdyo_d;       // hreadyout register
    logic [31:0]           hrd_q, hrd_d;         // hrdata register
    // software visible state
    logic [ADDR_W-1:0]     addr_q, addr_d;       // flash word address
    logic [DATA_W-1:0]     wdat_q, wdat_d;       // word to write
    logic [DATA_W-1:0]     rdat_q, rdat_d;       // last word read
    logic                  rst_q, rst_d;         // flash reset hold
    logic                  vpp_q, vpp_d;         // supply switch
    logic                  done_q, done_d;       // sticky done
    logic                  puls_q, puls_d;       // sticky pulse/lock failure
    logic                  vppl_q, vppl_d;       // sticky low supply
    logic                  tmo_q, tmo_d;         // sticky poll timeout
    // operation engine
    fssl_st_t              st_q, st_d;           // engine state
    logic [15:0]           pcnt_q, pcnt_d;       // poll pairs so far
    logic [DATA_W-1:0]     first_q, first_d;     // first word of a poll pair
    logic                  rechk_q, rechk_d;     // one more pair after fail bits
    logic                  rv_q, rv_d;           // cycle start pulse
    fssl_req_t             req_q, req_d;         // cycle request
    // ready pin synchroniser
    logic                  rdy_s1_q;             // first stage
    logic                  rdy_s2_q;             // second stage
    // from the cycle engine
    logic                  cyc_done;             // cycle finished
    logic [DATA_W-1:0]     cyc_rdata;            // word read

    // combinational helpers
    logic                  take;                 // address phase accepted
    logic                  wr_ctrl;              // control write in data phase
    logic                  wr_stat;              // status write in data phase
    logic [31:0]           rd_mux;               // register read value
    logic                  start;                // new operation accepted
    logic                  tog;                  // toggle bit moved between reads
    logic                  fbits;                // bit 5 or bit 3 raised

    assign take    = hsel & htrans[1] & hready;
    assign wr_ctrl = pend_q & pwr_q & (pofs_q == OFS_CTRL);
    assign wr_stat = pend_q & pwr_q & (pofs_q == OFS_STATUS);
    assign start   = wr_ctrl & (st_q == S_IDLE) & ~rst_q
                   & (hwdata[CTRL_OP_LSB +: 2] != FSSL_OP_NONE);
    assign tog     = first_q[DQ_TOGGLE] ^ cyc_rdata[DQ_TOGGLE];
    assign fbits   = cyc_rdata[DQ_PULSE] | cyc_rdata[DQ_VPPLOW];

    // the ready line is open-drain from another device: two flops first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdy_s1_q <= 1'b0;
            rdy_s2_q <= 1'b0;
        end else begin
            rdy_s1_q <= flash_rdy_i;
            rdy_s2_q <= rdy_s1_q;
        end
    end

    // register read view; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (pofs_q)
            OFS_CTRL: begin
                rd_mux[CTRL_RST_BIT] = rst_q;
                rd_mux[CTRL_VPP_BIT] = vpp_q;
            end
            OFS_ADDR:   rd_mux[ADDR_W-1:0] = addr_q;
            OFS_WDATA:  rd_mux[DATA_W-1:0] = wdat_q;
            OFS_RDATA:  rd_mux[DATA_W-1:0] = rdat_q;
            OFS_STATUS: begin
                rd_mux[ST_BUSY] = (st_q != S_IDLE);
                rd_mux[ST_DONE] = done_q;
                rd_mux[ST_PULS] = puls_q;
                rd_mux[ST_VPPL] = vppl_q;
                rd_mux[ST_TMO]  = tmo_q;
                rd_mux[ST_RDY]  = rdy_s2_q;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // bus slave: one wait state per transfer, answer registered
    always_comb begin
        pend_d = 1'b0;
        pwr_d  = pwr_q;
        pofs_d = pofs_q;
        rdyo_d = 1'b1;
        hrd_d  = hrd_q;
        if (pend_q) begin
            hrd_d = rd_mux;                      // writes leave a harmless value
        end else if (take) begin
            pend_d = 1'b1;
            pwr_d  = hwrite;
            pofs_d = haddr[7:0];
            rdyo_d = 1'b0;                       // stall so hrdata can come from a flop
        end
    end

    // software registers, sticky flags and the operation engine
    always_comb begin
        addr_d  = addr_q;
        wdat_d  = wdat_q;
        rdat_d  = rdat_q;
        rst_d   = rst_q;
        vpp_d   = vpp_q;
        st_d    = st_q;
        pcnt_d  = pcnt_q;
        first_d = first_q;
        rechk_d = rechk_q;
        rv_d    = 1'b0;
        req_d   = req_q;
        // write 1 clears; a set in the same cycle wins below
        done_d  = done_q & ~(wr_stat & hwdata[ST_DONE]);
        puls_d  = puls_q & ~(wr_stat & hwdata[ST_PULS]);
        vppl_d  = vppl_q & ~(wr_stat & hwdata[ST_VPPL]);
        tmo_d   = tmo_q  & ~(wr_stat & hwdata[ST_TMO]);
        // address and data registers only change while idle
        if (pend_q & pwr_q & (st_q == S_IDLE)) begin
            if (pofs_q == OFS_ADDR) begin
                addr_d = hwdata[ADDR_W-1:0];
            end
            if (pofs_q == OFS_WDATA) begin
                wdat_d = hwdata[DATA_W-1:0];
            end
        end
        if (wr_ctrl) begin
            rst_d = hwdata[CTRL_RST_BIT];        // only way to unlock sectors
            vpp_d = hwdata[CTRL_VPP_BIT];        // supply low inhibits program/erase
        end
        unique case (st_q)
            S_IDLE: begin
                if (start) begin
                    rv_d    = 1'b1;
                    req_d   = '{wr: (hwdata[CTRL_OP_LSB +: 2] == FSSL_OP_WRITE),
                                addr: addr_q, data: wdat_q};
                    pcnt_d  = 16'h0000;
                    rechk_d = 1'b0;
                    // each command cycle is one write op
                    st_d    = (hwdata[CTRL_OP_LSB +: 2] == FSSL_OP_POLL) ? S_POLL_A : S_CYC;
                end
            end
            S_CYC: begin
                if (cyc_done) begin
                    if (!req_q.wr) begin
                        rdat_d = cyc_rdata;      // lock bit read at offset 2 lands here
                    end
                    done_d = 1'b1;
                    st_d   = S_IDLE;
                end
            end
            S_POLL_A: begin
                if (cyc_done) begin
                    first_d = cyc_rdata;
                    rv_d    = 1'b1;              // second read of the pair
                    st_d    = S_POLL_B;
                end
            end
            S_POLL_B: begin
                if (cyc_done) begin
                    rdat_d = cyc_rdata;
                    if (!tog) begin
                        done_d = 1'b1;           // toggling stopped: valid data
                        st_d   = S_IDLE;
                    end else if (rechk_q | (pcnt_q == POLL_LIMIT)) begin
                        // still toggling after fail bits or at the poll limit: software must exit
                        puls_d = puls_d | cyc_rdata[DQ_PULSE];
                        vppl_d = vppl_d | cyc_rdata[DQ_VPPLOW];
                        tmo_d  = tmo_d | ~fbits;
                        done_d = 1'b1;
                        st_d   = S_IDLE;
                    end else begin
                        rechk_d = fbits;         // bit 6 may stop as bit 5 rises
                        pcnt_d  = pcnt_q + 16'h0001;
                        rv_d    = 1'b1;
                        st_d    = S_POLL_A;
                    end
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
    end

    // registers of the bus slave, software state and engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q  <= 1'b0;
            pwr_q   <= 1'b0;
            pofs_q  <= 8'h00;
            rdyo_q  <= 1'b1;
            hrd_q   <= 32'h0000_0000;
            addr_q  <= ADDR_RST;
            wdat_q  <= WDATA_RST;
            rdat_q  <= 16'h0000;
            rst_q   <= 1'b0;
            vpp_q   <= 1'b0;
            done_q  <= 1'b0;
            puls_q  <= 1'b0;
            vppl_q  <= 1'b0;
            tmo_q   <= 1'b0;
            st_q    <= S_IDLE;
            pcnt_q  <= 16'h0000;
            first_q <= 16'h0000;
            rechk_q <= 1'b0;
            rv_q    <= 1'b0;
            req_q   <= '{wr: 1'b0, addr: 20'h00000, data: 16'h0000};
        end else begin
            pend_q  <= pend_d;
            pwr_q   <= pwr_d;
            pofs_q  <= pofs_d;
            rdyo_q  <= rdyo_d;
            hrd_q   <= hrd_d;
            addr_q  <= addr_d;
            wdat_q  <= wdat_d;
            rdat_q  <= rdat_d;
            rst_q   <= rst_d;
            vpp_q   <= vpp_d;
            done_q  <= done_d;
            puls_q  <= puls_d;
            vppl_q  <= vppl_d;
            tmo_q   <= tmo_d;
            st_q    <= st_d;
            pcnt_q  <= pcnt_d;
            first_q <= first_d;
            rechk_q <= rechk_d;
            rv_q    <= rv_d;
            req_q   <= req_d;
        end
    end

    // pin cycle engine
    fssl_cycle u_cycle (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .req_valid (rv_q),
        .req       (req_q),
        .dq_i      (flash_dq_i),
        .done      (cyc_done),
        .rdata     (cyc_rdata),
        .pins      (flash_o)
    );

    assign hreadyout    = rdyo_q;
    assign hrdata       = hrd_q;
    assign hresp        = 1'b0;
    assign flash_rst_n  = ~rst_q;
    assign flash_vpp_en = vpp_q;

endmodule

// >>> fssl_ctrl_chk.sv
// Purpose: bus wait state and strobe shape checks
// Assumes: one hclk domain, reset hresetn
// Notes:   only the write strobe width is checked, as a lower bound
`timescale 1ns/10ps
module fssl_ctrl_chk (
    input  wire logic                  hclk,      // system clock
    input  wire logic                  hresetn,   // async reset, active low
    input  wire logic                  hsel,      // slave select
    input  wire logic [1:0]            htrans,    // transfer type
    input  wire logic                  hready,    // bus ready
    input  wire logic                  hreadyout, // slave ready out
    input  wire logic                  hresp,     // response
    input  wire fssl_pkg::fssl_pin_o_t flash_o    // flash pins
);
    import fssl_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire fssl_pin_o_t p  = flash_o;                   // short alias
    wire              tk = hsel && htrans[1] && hready; // accepted address phase
    AST_OKAY: assert property (hresp == 1'b0) else $error("not okay");
    AST_WAIT: assert property (tk |=> !hreadyout ##1 hreadyout) else $error("wait state wrong");
    AST_WR: assert property (!p.we_n |-> !p.ce_n && p.dq_oe && p.oe_n)
        else $error("strobe outside write");
    // never drive the data pins against the flash
    AST_RD: assert property (!p.oe_n |-> !p.ce_n && !p.dq_oe) else $error("read with drive on");
    AST_IDLE: assert property (p.ce_n |-> !p.dq_oe) else $error("drive when idle");
    AST_WP: assert property ($fell(p.we_n) |-> !p.we_n [*8])
        else $error("strobe short");
    AST_SETUP: assert property ($fell(p.we_n) |-> !$past(p.ce_n, 5))
        else $error("no setup");
    AST_HOLD: assert property ($rose(p.we_n) |-> (!p.ce_n && $stable(p.addr)) [*4])
        else $error("no hold");
    AST_STABLE: assert property (!p.ce_n && $past(!p.ce_n) |-> $stable({p.addr, p.dq}))
        else $error("pins moved");
    COV_WR: cover property ($rose(p.we_n));
    COV_RD: cover property ($rose(p.oe_n));
    COV_BUS: cover property (tk);
endmodule
bind fssl_ctrl fssl_ctrl_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout,
    .hresp, .flash_o);

// >>> fssl_flash_mdl.sv
// Purpose: behavioural flash answering word loads and status reads
// Assumes: every write but 16'h00f0 loads a word; data 16'h00f0 acts as the exit command
// Notes:   no array, reads give the last loaded word unless busy or faulted
`timescale 1ns/10ps
module fssl_flash_mdl (
    input  wire fssl_pkg::fssl_pin_o_t pins,   // controller pin drive
    input  wire logic                  vpp_en, // program supply switch
    output logic [15:0]                dq,     // data the flash drives
    output logic                       rdy     // ready line after pull-up
);
    import fssl_pkg::*;
    logic [15:0] word_q = 16'h0000; // last loaded word
    logic [15:0] st;                // status word
    logic [1:0]  left_q = 2'h0;     // busy reads still to come
    logic        tog_q  = 1'b0;     // toggle bit
    logic        vlow_q = 1'b0;     // supply fault held until exit or a load with supply on
    // data taken at the strobe rise, while chip enable is still low
    always @(posedge pins.we_n) if (!pins.ce_n) begin
        if (pins.dq == 16'h00f0) vlow_q = 1'b0;
        else begin
            word_q = pins.dq;
            left_q = vpp_en ? 2'h3 : 2'h0;
            vlow_q = !vpp_en;
        end
    end
    // busy reads flip the toggle bit; each read end counts down
    always @(negedge pins.oe_n) if (left_q != 2'h0 || vlow_q) tog_q = ~tog_q;
    always @(posedge pins.oe_n) if (left_q != 2'h0) left_q = left_q - 2'h1;
    assign st = {8'h00, left_q != 2'h0 && !word_q[7], tog_q, 2'b00, vlow_q, 3'b000};
    // a released bus shows the inverse, so stale samples stand out
    assign dq = (pins.ce_n || pins.oe_n) ? ~st : (left_q != 2'h0 || vlow_q) ? st : word_q;
    assign rdy = (left_q == 2'h0);
endmodule

// >>> fssl_ctrl_tb_top.sv
// Purpose: self-checking bench for the flash controller
// Assumes: flash model on the far side
// Notes:   a spent wait bound counts as a mismatch
`timescale 1ns/10ps
module fssl_ctrl_tb_top;
    import fssl_pkg::*;
    logic        hclk, hresetn, hwrite, hreadyout, hresp, flash_rst_n, flash_vpp_en, rdy;
    logic [1:0]  htrans;                   // transfer type
    logic [31:0] haddr, hwdata, hrdata, rd; // bus lines, last read word
    logic [15:0] mdq, dq_i;                // model drive, wire level
    fssl_pin_o_t flash_o;                  // controller pins
    int          mismatches, num_checks;   // counters
    assign dq_i = flash_o.dq_oe ? flash_o.dq : mdq; // shared data wire
    fssl_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flash_o(flash_o),
        .flash_dq_i(dq_i), .flash_rdy_i(rdy), .flash_rst_n(flash_rst_n),
        .flash_vpp_en(flash_vpp_en));
    fssl_flash_mdl u_mem (.pins(flash_o), .vpp_en(flash_vpp_en), .dq(mdq), .rdy(rdy));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    // end the run once a bound is spent
    task automatic wait_n(input logic c, input int lim, n);
        if (!c && n >= lim) begin
            mismatches++;
            give_verdict();
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {htrans, haddr, hwrite} <= {2'h2, 24'h0, a, w};
        for (int n = 0; n < 2; n++) begin
            if (n == 1) {htrans, hwdata} <= {2'h0, d};
            for (int k = 0; k <= 20; k++) begin
                @(posedge hclk);
                wait_n(hreadyout === 1'b1, 20, k);
                if (hreadyout === 1'b1) break;
            end
        end
        rd = hrdata;
    endtask
    // start an op, poll status until idle
    task automatic run(input logic [7:0] c);
        ahb(1'b1, OFS_CTRL, {24'h0, c});
        for (int n = 0; n <= 500; n++) begin
            ahb(1'b0, OFS_STATUS, 32'h0);
            wait_n(rd[ST_BUSY] === 1'b0, 500, n);
            if (rd[ST_BUSY] === 1'b0) break;
        end
    endtask
    task automatic t_reset; // idle status, unmapped place, reset pin
        ahb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h20);
        ahb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b1, OFS_CTRL, 32'h10);
        chk({31'h0, flash_rst_n}, 32'h0);
        ahb(1'b1, OFS_CTRL, 32'h00);
    endtask
    task automatic t_prog; // load with supply on, poll to completion
        ahb(1'b1, OFS_ADDR, 32'h00345);
        ahb(1'b1, OFS_WDATA, 32'h1234);
        run(8'h21);
        run(8'h23);
        chk(rd, 32'h22);
        ahb(1'b0, OFS_RDATA, 32'h0);
        chk(rd, 32'h1234);
        chk({31'h0, flash_vpp_en}, 32'h1);
    endtask
    task automatic t_vlow; // supply off faults, exit clears it
        run(8'h01);
        run(8'h03);
        chk(rd, 32'h2a);
        ahb(1'b1, OFS_STATUS, 32'h1e);
        ahb(1'b1, OFS_WDATA, 32'h00f0);
        run(8'h01);
        run(8'h03);
        chk(rd, 32'h22);
        run(8'h02);
        ahb(1'b0, OFS_RDATA, 32'h0);
        chk(rd, 32'h1234);
    endtask
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata, mismatches, num_checks} = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_prog();
        t_vlow();
        give_verdict();
    end
endmodule
